// ---- src/flame_pkg.sv ----
// shared constants for the flame supervision block
package flame_pkg;
  // ===========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int BLINK_MS = 1000;
  localparam int BLINK_CYC = CLK_MHZ * 1000 * BLINK_MS / 2;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = CLK_MHZ * 1000 * DEB_MS;
  localparam int SHUT_HALF_MS = 100;
  localparam int SHUT_CYC = CLK_MHZ * 1000 * SHUT_HALF_MS;
  // ===========================================================
  // flame voltage thresholds, 8-bit code spans full scale
  localparam int FS_MV = 5000;
  localparam int GREEN_MV = 2500;
  localparam int ORANGE_MV = 1500;
  localparam logic [7:0] GREEN_CODE = 8'((GREEN_MV * 256 + FS_MV - 1) / FS_MV);
  localparam logic [7:0] ORANGE_CODE = 8'((ORANGE_MV * 256 + FS_MV - 1) / FS_MV);
  // ===========================================================
  // register map
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [3:0] LIMIT_PAGE = 4'h1;
  localparam logic [3:0] COUNT_PAGE = 4'h2;
  localparam int CFG_SC_LSB = 0;
  localparam int CFG_FL_LSB = 2;
  localparam int CFG_LVL_BIT = 4;
  localparam int CFG_AUX_LSB = 5;
  localparam logic [7:0] CFG_RST = 8'h65;
  localparam int ST_EVENT_BIT = 0;
  localparam int ST_DUE_LSB = 4;
  localparam int CNT_W = 16;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ===========================================================
  // auxiliary relay modes
  localparam logic [2:0] AUX_SC = 3'h1;
  localparam logic [2:0] AUX_FL = 3'h2;
  localparam logic [2:0] AUX_EVENT = 3'h3;
  localparam logic [2:0] AUX_DUE = 3'h4;
  typedef enum logic [1:0] {ST_STOP, ST_CHECK, ST_RUN, ST_FAULT} seq_e;
endpackage : flame_pkg

// ---- src/pulse_timebase.sv ----
// half-period timebase giving a square phase, a slower alternate and a toggle tick
`timescale 1ns/1ps
module pulse_timebase #(
  parameter int HALF = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  output logic phase,
  output logic alt,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      phase <= 1'b0;
      alt <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        cnt_ff <= 32'h0;
        phase <= 1'b0;
      end else if (cnt_ff == 32'(HALF - 1)) begin
        cnt_ff <= 32'h0;
        phase <= !phase;
        tick <= 1'b1;
        if (phase) begin
          alt <= !alt;
        end
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end
endmodule : pulse_timebase

// ---- src/switch_debounce.sv ----
// debounces a switch and pulses once when it settles pressed
`timescale 1ns/1ps
module switch_debounce #(
  parameter int CYC = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic raw,
  output logic press
);
  logic [31:0] cnt_ff;
  logic stable_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      stable_ff <= 1'b0;
      press <= 1'b0;
    end else if (ce) begin
      press <= 1'b0;
      if (raw == stable_ff) begin
        cnt_ff <= 32'h0;
      end else if (cnt_ff == 32'(CYC - 1)) begin
        cnt_ff <= 32'h0;
        stable_ff <= raw;
        press <= raw;
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end
endmodule : switch_debounce

// ---- src/flame_supervisor.sv ----
// flame supervision: relay sequencing, shutter self-check, LEDs, counters, bus slave
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module flame_supervisor #(
  parameter int BLINK_HALF = flame_pkg::BLINK_CYC,
  parameter int SHUT_HALF = flame_pkg::SHUT_CYC,
  parameter int DEB_CYC = flame_pkg::DEB_CYC,
  parameter int CNT_W = flame_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start_in,
  input wire logic event_in,
  input wire logic amp_fault_in,
  input wire logic flame_sense,
  input wire logic [7:0] flame_level,
  input wire logic [2:0] counter_select_switch,
  input wire logic counter_reset_switch,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic start_check_relay,
  output logic flame_relay,
  output logic auxiliary_event_relay,
  output logic shutter_drive,
  output logic sc_led_green,
  output logic sc_led_red,
  output logic fl_led_green,
  output logic fl_led_red
);
  // ===========================================================
  // reset release
  logic rst_meta_ff;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ===========================================================
  // state
  flame_pkg::seq_e state_ff;
  flame_pkg::seq_e nxt_state;
  logic [7:0] cfg_ff;
  logic event_ff;
  logic dark_seen_ff;
  logic lit_seen_ff;
  logic [CNT_W-1:0] limit_ff [4];
  logic [CNT_W-1:0] count_ff [4];
  logic [3:0] due;
  logic blink;
  logic blink_alt;
  logic shut_open;
  logic shut_tick;
  logic clr_press;
  logic running;
  logic fault_now;
  logic flame_lost;
  logic wr_go;
  logic clr_event;
  logic [7:0] aw_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [31:0] rd_mux;
  logic rd_ok;

  assign running = (state_ff == flame_pkg::ST_CHECK) || (state_ff == flame_pkg::ST_RUN);

  pulse_timebase #(.HALF(BLINK_HALF)) u_blink (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .run(1'b1),
    .phase(blink),
    .alt(blink_alt),
    .tick()
  );

  pulse_timebase #(.HALF(SHUT_HALF)) u_shutter (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .run(running),
    .phase(shut_open),
    .alt(),
    .tick(shut_tick)
  );

  switch_debounce #(.CYC(DEB_CYC)) u_reset_sw (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .raw(counter_reset_switch),
    .press(clr_press)
  );

  // ===========================================================
  // shutter self-check
  // a tick while open ends a closed half, and the reverse
  assign fault_now = amp_fault_in || (shut_tick && shut_open && dark_seen_ff);
  assign flame_lost = shut_tick && !shut_open && !lit_seen_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dark_seen_ff <= 1'b0;
      lit_seen_ff <= 1'b0;
      shutter_drive <= 1'b0;
    end else if (ce) begin
      shutter_drive <= shut_open;
      if (!running || shut_tick) begin
        dark_seen_ff <= 1'b0;
        lit_seen_ff <= 1'b0;
      end else if (flame_sense) begin
        dark_seen_ff <= dark_seen_ff || !shut_open;
        lit_seen_ff <= lit_seen_ff || shut_open;
      end
    end
  end

  // ===========================================================
  // sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flame_pkg::ST_STOP: begin
        if (start_in && !amp_fault_in) begin
          nxt_state = flame_pkg::ST_CHECK;
        end
      end
      flame_pkg::ST_CHECK: begin
        if (!start_in) begin
          nxt_state = flame_pkg::ST_STOP;
        end else if (fault_now) begin
          nxt_state = flame_pkg::ST_FAULT;
        end else if (shut_tick && !shut_open && lit_seen_ff) begin
          nxt_state = flame_pkg::ST_RUN;
        end
      end
      flame_pkg::ST_RUN: begin
        if (!start_in || flame_lost) begin
          nxt_state = flame_pkg::ST_STOP;
        end else if (fault_now) begin
          nxt_state = flame_pkg::ST_FAULT;
        end
      end
      flame_pkg::ST_FAULT: begin
        if (!start_in) begin
          nxt_state = flame_pkg::ST_STOP;
        end
      end
      default: nxt_state = flame_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= flame_pkg::ST_STOP;
      start_check_relay <= 1'b0;
      flame_relay <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      start_check_relay <= running;
      flame_relay <= state_ff == flame_pkg::ST_RUN;
    end
  end

  // ===========================================================
  // event flag, set wins over the clear
  assign clr_event = wr_go && aw_ff == flame_pkg::STAT_OFS && ws_ff[0]
    && wd_ff[flame_pkg::ST_EVENT_BIT];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_ff <= 1'b0;
    end else if (ce) begin
      if (event_in || (running && (fault_now || flame_lost))) begin
        event_ff <= 1'b1;
      end else if (clr_event) begin
        event_ff <= 1'b0;
      end
    end
  end

  // ===========================================================
  // inspection counters: one count per burner start
  for (genvar i = 0; i < 4; i++) begin : g_insp
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        count_ff[i] <= '0;
        limit_ff[i] <= '0;
      end else if (ce) begin
        if (clr_press && counter_select_switch == 3'(i + 1)) begin
          count_ff[i] <= '0;
        end else if (state_ff == flame_pkg::ST_STOP && nxt_state == flame_pkg::ST_CHECK
            && count_ff[i] != '1) begin
          count_ff[i] <= count_ff[i] + 1'b1;
        end
        if (wr_go && aw_ff[7:4] == flame_pkg::LIMIT_PAGE && aw_ff[3:2] == 2'(i)) begin
          if (ws_ff[0]) begin
            limit_ff[i][7:0] <= wd_ff[7:0];
          end
          if (ws_ff[1]) begin
            limit_ff[i][CNT_W-1:8] <= wd_ff[CNT_W-1:8];
          end
        end
      end
    end
    assign due[i] = limit_ff[i] != '0 && count_ff[i] >= limit_ff[i];
  end

  // ===========================================================
  // indicators
  logic [1:0] sc_code;
  logic [1:0] fl_code;
  logic stopped;
  logic use_lvl;
  logic lvl_g;
  logic lvl_o;
  logic nxt_sc_g;
  logic nxt_sc_r;
  logic nxt_fl_g;
  logic nxt_fl_r;
  logic nxt_aux;
  assign sc_code = cfg_ff[flame_pkg::CFG_SC_LSB +: 2];
  assign fl_code = cfg_ff[flame_pkg::CFG_FL_LSB +: 2];
  assign stopped = !start_check_relay && !flame_relay;
  assign use_lvl = fl_code == 2'h1 || cfg_ff[flame_pkg::CFG_LVL_BIT];
  assign lvl_g = flame_level >= flame_pkg::GREEN_CODE;
  assign lvl_o = !lvl_g && flame_level >= flame_pkg::ORANGE_CODE;

  always_comb begin
    nxt_sc_g = start_check_relay;
    nxt_sc_r = 1'b0;
    if (event_ff && sc_code != 2'h0) begin
      nxt_sc_g = start_check_relay && blink;
      nxt_sc_r = start_check_relay ? blink && blink_alt : blink;
    end else if (stopped && ((sc_code == 2'h2 && due[0]) || (sc_code == 2'h3 && due[1]))) begin
      nxt_sc_g = 1'b0;
      nxt_sc_r = blink;
    end
  end

  always_comb begin
    nxt_fl_g = flame_relay;
    nxt_fl_r = 1'b0;
    if (use_lvl) begin
      nxt_fl_g = flame_relay && (lvl_g || lvl_o);
      nxt_fl_r = flame_relay && !lvl_g;
    end
    if (stopped && ((fl_code == 2'h2 && due[2]) || (fl_code == 2'h3 && due[3]))) begin
      nxt_fl_g = 1'b0;
      nxt_fl_r = blink;
    end
  end

  always_comb begin
    case (cfg_ff[flame_pkg::CFG_AUX_LSB +: 3])
      flame_pkg::AUX_SC: nxt_aux = start_check_relay;
      flame_pkg::AUX_FL: nxt_aux = flame_relay;
      flame_pkg::AUX_EVENT: nxt_aux = event_ff;
      flame_pkg::AUX_DUE: nxt_aux = |due;
      default: nxt_aux = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sc_led_green <= 1'b0;
      sc_led_red <= 1'b0;
      fl_led_green <= 1'b0;
      fl_led_red <= 1'b0;
      auxiliary_event_relay <= 1'b0;
    end else if (ce) begin
      sc_led_green <= nxt_sc_g;
      sc_led_red <= nxt_sc_r;
      fl_led_green <= nxt_fl_g;
      fl_led_red <= nxt_fl_r;
      auxiliary_event_relay <= nxt_aux;
    end
  end

  // ===========================================================
  // bus write channel
  assign wr_go = aw_have_ff && w_have_ff && !bvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_ff <= 8'h00;
      wd_ff <= 32'h0;
      ws_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= flame_pkg::RESP_OK;
      cfg_ff <= flame_pkg::CFG_RST;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_have_ff <= 1'b1;
        aw_ff <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_have_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (aw_ff == flame_pkg::CFG_OFS || aw_ff == flame_pkg::STAT_OFS
          || aw_ff[7:4] == flame_pkg::LIMIT_PAGE) ? flame_pkg::RESP_OK : flame_pkg::RESP_ERR;
        if (aw_ff == flame_pkg::CFG_OFS && ws_ff[0]) begin
          cfg_ff <= wd_ff[7:0];
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ===========================================================
  // bus read channel
  always_comb begin
    rd_mux = 32'h0;
    rd_ok = 1'b1;
    if (araddr[7:2] == flame_pkg::CFG_OFS[7:2]) begin
      rd_mux[7:0] = cfg_ff;
    end else if (araddr[7:2] == flame_pkg::STAT_OFS[7:2]) begin
      rd_mux[flame_pkg::ST_EVENT_BIT] = event_ff;
      rd_mux[1] = state_ff == flame_pkg::ST_FAULT;
      rd_mux[2] = start_check_relay;
      rd_mux[3] = flame_relay;
      rd_mux[flame_pkg::ST_DUE_LSB +: 4] = due;
      rd_mux[8] = shutter_drive;
    end else if (araddr[7:4] == flame_pkg::LIMIT_PAGE) begin
      rd_mux[CNT_W-1:0] = limit_ff[araddr[3:2]];
    end else if (araddr[7:4] == flame_pkg::COUNT_PAGE) begin
      rd_mux[CNT_W-1:0] = count_ff[araddr[3:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= flame_pkg::RESP_OK;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? flame_pkg::RESP_OK : flame_pkg::RESP_ERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ===========================================================
  // checks
  sequence s_pick_first;
    ce && clr_press && counter_select_switch == 3'h1;
  endsequence

  a_fault_relays_off: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_ff == flame_pkg::ST_FAULT |=> !flame_relay && !start_check_relay)
    else $error("relay on in fault");
  a_run_both_on: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_ff == flame_pkg::ST_RUN |=> flame_relay && start_check_relay)
    else $error("relays not on in run");
  a_stop_both_off: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_ff == flame_pkg::ST_STOP |=> !flame_relay && !start_check_relay)
    else $error("relays on while stopped");
  a_clear_count: assert property (@(posedge clock) disable iff (!rst_n)
    s_pick_first |=> count_ff[0] == '0)
    else $error("counter not cleared");
  a_level_dark: assert property (@(posedge clock) disable iff (!rst_n)
    ce && fl_code == 2'h1 && !flame_relay |=> !fl_led_green && !fl_led_red)
    else $error("level LED lit with relay off");
  a_level_green: assert property (@(posedge clock) disable iff (!rst_n)
    ce && fl_code == 2'h1 && flame_relay && flame_level >= 8'h80 |=> fl_led_green && !fl_led_red)
    else $error("level green wrong");
  a_aux_event: assert property (@(posedge clock) disable iff (!rst_n)
    ce && cfg_ff[7:5] == 3'h3 |=> auxiliary_event_relay == $past(event_ff))
    else $error("aux relay not following event");
  a_sc_sync: assert property (@(posedge clock) disable iff (!rst_n)
    ce && sc_code == 2'h0 |=> sc_led_green == $past(start_check_relay) && !sc_led_red)
    else $error("start LED out of step");
  a_event_wins: assert property (@(posedge clock) disable iff (!rst_n)
    ce && event_ff && sc_code == 2'h2 && stopped |=> sc_led_red == $past(blink) && !sc_led_green)
    else $error("event not shown first");
  a_shutter_idle: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_ff == flame_pkg::ST_STOP ##1 ce |=> !shutter_drive)
    else $error("shutter moving while stopped");
endmodule : flame_supervisor

// ---- bench/uv_detector_model.sv ----
// behavioural ultraviolet flame detector with a shutter in front of the tube
`timescale 1ns/1ps
module uv_detector_model (
  input wire logic shutter_drive,
  input wire logic flame_on,
  input wire logic leak,
  output logic flame_sense
);
  // ===========================================================
  // pulses only through an open shutter; leak models a failed tube that fires when closed
  assign flame_sense = (shutter_drive & flame_on) | leak;
endmodule : uv_detector_model

// ---- bench/test_burner_status_indicator_logic.sv ----
// self-checking bench for the flame supervision block
`timescale 1ns/1ps
module test_burner_status_indicator_logic;
  logic clock, arst_n, start_in, event_in, amp_fault_in, flame_sense, counter_reset_switch;
  logic flame_on, leak;
  logic [7:0] flame_level, awaddr, araddr;
  logic [2:0] counter_select_switch;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic start_check_relay, flame_relay, auxiliary_event_relay, shutter_drive;
  logic sc_led_green, sc_led_red, fl_led_green, fl_led_red;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int nr, no, ng;
  // ===========================================================
  // design and detector
  flame_supervisor #(.BLINK_HALF(8), .SHUT_HALF(6), .DEB_CYC(3), .CNT_W(16)) i_dut (
    .clock(clock), .arst_n(arst_n), .ce(1'b1), .start_in(start_in), .event_in(event_in),
    .amp_fault_in(amp_fault_in), .flame_sense(flame_sense), .flame_level(flame_level),
    .counter_select_switch(counter_select_switch), .counter_reset_switch(counter_reset_switch),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .start_check_relay(start_check_relay),
    .flame_relay(flame_relay), .auxiliary_event_relay(auxiliary_event_relay),
    .shutter_drive(shutter_drive), .sc_led_green(sc_led_green), .sc_led_red(sc_led_red),
    .fl_led_green(fl_led_green), .fl_led_red(fl_led_red));
  uv_detector_model i_uv (.shutter_drive(shutter_drive), .flame_on(flame_on), .leak(leak),
    .flame_sense(flame_sense));
  // ===========================================================
  // clock, timeout, closing
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  // ===========================================================
  // bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
    // let an edge pass so a following write never reassigns bready in this step
    @(posedge clock);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask : axr
  task automatic watch();
    nr = 0;
    no = 0;
    ng = 0;
    repeat (40) begin
      @(posedge clock);
      nr += sc_led_red;
      no += sc_led_red & sc_led_green;
      ng += sc_led_green & ~sc_led_red;
    end
  endtask : watch
  task automatic wait_run();
    for (int n = 0; n < 100 && flame_relay !== 1'b1; n++) @(posedge clock);
    // the LEDs register the relay one edge later
    @(posedge clock);
  endtask : wait_run
  // ===========================================================
  // scenarios
  task automatic t_reset();
    axr(8'h00, d, r);
    chk(d & 32'h000000ff, 32'h00000065, "config reset value");
    axr(8'h40, d, r);
    chk({30'h0, r}, 32'h00000002, "unmapped read response");
    axw(8'h24, 32'h00000000, r);
    chk({30'h0, r}, 32'h00000002, "count write refused");
  endtask : t_reset
  task automatic t_run();
    flame_on <= 1'b1;
    flame_level <= 8'hc8;
    start_in <= 1'b1;
    wait_run();
    chk({30'h0, start_check_relay, flame_relay}, 32'h00000003, "relays in run");
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000002, "flame led green");
    chk({31'h0, auxiliary_event_relay}, 32'h00000000, "aux idle");
    flame_level <= 8'h64;
    repeat (4) @(posedge clock);
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000003, "flame led orange");
    flame_level <= 8'h32;
    repeat (4) @(posedge clock);
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000001, "flame led red");
  endtask : t_run
  task automatic t_event_run();
    event_in <= 1'b1;
    @(posedge clock);
    event_in <= 1'b0;
    watch();
    chk({31'h0, no > 5 && no < 35}, 32'h00000001, "orange alternation in run");
    chk({31'h0, ng > 5}, 32'h00000001, "green blinks between orange");
    chk({31'h0, auxiliary_event_relay}, 32'h00000001, "aux on event");
  endtask : t_event_run
  task automatic t_amp();
    amp_fault_in <= 1'b1;
    repeat (4) @(posedge clock);
    chk({30'h0, start_check_relay, flame_relay}, 32'h00000000, "amp fault drops");
    axr(8'h04, d, r);
    chk(d & 32'h00000002, 32'h00000002, "fault status");
    amp_fault_in <= 1'b0;
    start_in <= 1'b0;
    repeat (4) @(posedge clock);
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000000, "flame led dark");
    watch();
    chk({31'h0, nr > 5 && nr < 35}, 32'h00000001, "red blink stopped");
    axw(8'h04, 32'h00000001, r);
  endtask : t_amp
  task automatic t_due();
    axw(8'h10, 32'h00000001, r);
    axw(8'h00, 32'h00000066, r);
    axr(8'h04, d, r);
    chk(d & 32'h00000011, 32'h00000010, "due1 only");
    watch();
    chk({31'h0, nr > 5 && nr < 35}, 32'h00000001, "due blink");
    counter_select_switch <= 3'h1;
    counter_reset_switch <= 1'b1;
    repeat (10) @(posedge clock);
    counter_reset_switch <= 1'b0;
    repeat (10) @(posedge clock);
    axr(8'h20, d, r);
    chk(d, 32'h00000000, "count1 cleared");
    watch();
    chk(nr, 32'h00000000, "no blink after clear");
  endtask : t_due
  task automatic t_leak();
    start_in <= 1'b1;
    wait_run();
    leak <= 1'b1;
    repeat (30) @(posedge clock);
    chk({30'h0, start_check_relay, flame_relay}, 32'h00000000, "detector fault drops");
    leak <= 1'b0;
    start_in <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : t_leak
  task automatic t_modes();
    axw(8'h18, 32'h00000001, r);
    axw(8'h00, 32'h00000088, r);
    nr = 0;
    no = 0;
    repeat (40) begin
      @(posedge clock);
      nr += fl_led_red;
      no += fl_led_green | sc_led_green | sc_led_red;
    end
    chk({31'h0, nr > 5 && nr < 35}, 32'h00000001, "due3 blink stopped");
    chk(no, 32'h00000000, "relay leds dark while stopped");
    chk({31'h0, auxiliary_event_relay}, 32'h00000001, "aux on due");
    start_in <= 1'b1;
    wait_run();
    chk({30'h0, sc_led_green, sc_led_red}, 32'h00000002, "start led follows relay");
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000002, "flame led follows relay");
    axw(8'h00, 32'h00000098, r);
    chk({30'h0, fl_led_green, fl_led_red}, 32'h00000001, "level colour in setting 3");
    axw(8'h00, 32'h00000038, r);
    chk({31'h0, auxiliary_event_relay}, 32'h00000001, "aux follows start relay");
    start_in <= 1'b0;
    repeat (4) @(posedge clock);
    chk({31'h0, auxiliary_event_relay}, 32'h00000000, "aux drops with start relay");
  endtask : t_modes
  // ===========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    {start_in, event_in, amp_fault_in, counter_reset_switch, flame_on, leak} = 6'h00;
    flame_level = 8'h00;
    counter_select_switch = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_run();
    t_event_run();
    t_amp();
    t_due();
    t_leak();
    t_modes();
    end_sim();
  end
endmodule : test_burner_status_indicator_logic
